//--- counter_signal_routing_tb.sv
// Self-checking bench of the counter signal router
`timescale 1ns/1ps
`include "crs_consts.vh"
module counter_signal_routing_tb;
  reg         i_clk_sys = 1'b0;
  reg         i_rstn = 1'b0;
  reg  [7:0]  i_addr = 8'h00;
  reg  [31:0] i_wdata = 32'h0;
  reg         i_wr = 1'b0;
  reg         i_rd = 1'b0;
  reg         mid = 1'b0;
  reg         run = 1'b0;
  reg  [3:0]  sel = 4'h2;
  reg  [1:0]  dir = 2'h0;
  wire [31:0] o_rdata;
  wire [9:0]  pin_in, pin_out, pin_oe_n;
  wire [7:0]  trg_in;
  wire [6:0]  trg_out, trg_oe_n;
  wire [1:0]  dirw;
  wire        c0_out, c0_oe_n, dco;
  reg  [31:0] q, w;
  reg  [23:0] ld;
  integer     miscompares = 0;
  integer     checks = 0;
  integer     c, m, n;
  time        t0;
  always #20 i_clk_sys = ~i_clk_sys;
  always @(posedge i_clk_sys) mid <= ~mid;
  crs_top uut (.i_clk_sys, .i_rstn, .i_ce(1'b1), .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .i_function_pin(pin_in), .o_function_pin(pin_out), .o_function_pin_oe_n(pin_oe_n),
    .i_shared_trigger_bus(trg_in), .o_shared_trigger_bus(trg_out),
    .o_shared_trigger_bus_oe_n(trg_oe_n), .i_counter_zero_pin(c0_oe_n | c0_out),
    .o_counter_zero_pin(c0_out), .o_counter_zero_pin_oe_n(c0_oe_n), .o_counter_one_pin(),
    .i_direction_line_zero(dirw[0]), .i_direction_line_one(dirw[1]),
    .i_fast_internal_timebase(1'b0), .i_mid_internal_timebase(mid),
    .i_slow_internal_timebase(1'b0), .o_ai_sample_clk(), .o_ai_start_trig(),
    .o_ai_convert_clk(), .o_ao_sample_clk(), .o_do_sample_clk(), .o_di_sample_clk(),
    .o_divided_clock_out(dco));
  crs_ext_model m_ext (.i_clk_sys, .i_run(run), .i_sel(sel), .i_dir(dir),
    .i_pin_drv(pin_out), .i_pin_oe_n(pin_oe_n), .i_trg_drv(trg_out),
    .i_trg_oe_n(trg_oe_n), .o_pin(pin_in), .o_trg(trg_in), .o_dir(dirw));
  function [31:0] exp_cnt(input [23:0] b, input integer k, input up);
    exp_cnt = {8'h00, up ? b + k[23:0] : b - k[23:0]};
  endfunction
  task chk(input [31:0] got, input [31:0] exp);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    begin
      @(posedge i_clk_sys);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_clk_sys);
      i_wr <= 1'b0;
    end
  endtask
  task rd(input [7:0] a, output [31:0] d);
    begin
      @(posedge i_clk_sys);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_clk_sys);
      i_rd <= 1'b0;
      #1 d = o_rdata;
    end
  endtask
  task pulses(input integer k);
    begin
      run <= 1'b1;
      repeat (4 * k) @(posedge i_clk_sys);
      run <= 1'b0;
      repeat (4) @(posedge i_clk_sys);
    end
  endtask
  task wrap_up;
    begin
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  initial begin
    #400_000;
    miscompares = miscompares + 1;
    wrap_up;
  end
  initial begin
    void'($urandom(14852));
    repeat (6) @(posedge i_clk_sys);
    i_rstn <= 1'b1;
    chk({c0_oe_n, trg_oe_n, pin_oe_n}, 18'h3FFFF);
    w = $urandom & 32'h93FF;
    wr(`CRS_A_CTRL1, w);
    rd(`CRS_A_CTRL1, q);
    chk(q, w);
    rd(8'h34, q);
    chk(q, 32'h0);
    for (c = 0; c < 2; c = c + 1)
      for (m = 0; m < 4; m = m + 1) begin
        ld = 24'h100 + $urandom % 24'h7FFF00;
        n = 3 + $urandom % 8;
        w = $urandom % 10;
        q = $urandom;
        sel <= w[3:0];
        dir <= {2{m[0]}};
        wr(`CRS_A_ROUTE, $urandom & 32'h3F);
        wr(`CRS_A_TRIG, $urandom & 32'h13FFF);
        wr({c[5:0], 2'h0}, {w[3:0], 2'h0, !m[1], m[1] && !m[0], q[0], 2'h0, 1'b1});
        wr(`CRS_A_LOAD0 | {c[5:0], 2'h0}, {8'h00, ld});
        pulses(n);
        rd(`CRS_A_COUNT0 | {c[5:0], 2'h0}, q);
        chk(q, exp_cnt(ld, n, m[1] ? !m[0] : m[0]));
      end
    sel <= 4'h2;
    wr(`CRS_A_STATUS, 32'hF);
    wr(`CRS_A_CTRL0, 32'h0203);
    wr(`CRS_A_LOAD0, 32'h2);
    pulses(5);
    rd(`CRS_A_STATUS, q);
    chk(q & 32'h1, 32'h1);
    chk(q[8], 1'b1);
    wr(`CRS_A_STATUS, 32'h1);
    rd(`CRS_A_STATUS, q);
    chk(q & 32'h1, 32'h0);
    wr(`CRS_A_PINOUT, 32'h110);
    wr(`CRS_A_TRIG, 32'h1);
    for (m = 0; m < 2; m = m + 1) begin
      wr(`CRS_A_CTRL1, 32'hA0C0);
      wr(`CRS_A_CTRL0, 32'h0200 | m << 2);
      wr(`CRS_A_LOAD0, 32'h10);
      repeat (4) @(posedge i_clk_sys);
      rd(`CRS_A_STATUS, q);
      chk(q[8], m[0]);
      chk(pin_out[4], m[0]);
      chk(q[3], m[0]);
      chk(trg_out[0], m[0]);
      wr(`CRS_A_CTRL1, 32'h5000);
      wr(`CRS_A_PINCFG, m << 5);
      repeat (4) @(posedge i_clk_sys);
      chk(pin_out[4], !m[0]);
    end
    chk(pin_out[8], 1'b1);
    chk(pin_oe_n, 10'h2EF);
    wr(`CRS_A_PINOUT, 32'h0);
    sel <= 4'hA;
    for (m = 0; m < 2; m = m + 1) begin
      wr(`CRS_A_TRIG, m ? 32'h0 : 32'h20000);
      wr(`CRS_A_CTRL0, 32'h0A11);
      wr(`CRS_A_LOAD0, 32'h1000);
      pulses(6);
      rd(`CRS_A_COUNT0, q);
      chk(q, exp_cnt(24'h1000, m ? 0 : 6, 1'b1));
    end
    for (m = 1; m <= 16; m = m + 1) begin
      wr(`CRS_A_ROUTE, (m - 1) << 8 | 32'h30);
      @(posedge dco);
      @(posedge dco);
      t0 = $time;
      @(posedge dco);
      chk(32'(($time - t0) / 40), 2 * m);
    end
    wrap_up;
  end
endmodule // counter_signal_routing_tb

//--- crs_consts.vh
// Register map, field positions and selector codes of the counter signal router
`ifndef CRS_CONSTS_VH
`define CRS_CONSTS_VH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define CRS_A_CTRL0   8'h00
`define CRS_A_CTRL1   8'h04
`define CRS_A_LOAD0   8'h08
`define CRS_A_LOAD1   8'h0C
`define CRS_A_COUNT0  8'h10
`define CRS_A_COUNT1  8'h14
`define CRS_A_LATCH0  8'h18
`define CRS_A_LATCH1  8'h1C
`define CRS_A_PINCFG  8'h20
`define CRS_A_PINOUT  8'h24
`define CRS_A_TRIG    8'h28
`define CRS_A_ROUTE   8'h2C
`define CRS_A_STATUS  8'h30

// ****************************************
// Counter control fields
// ****************************************
`define CRS_F_ARM     0
`define CRS_F_TOG     1
`define CRS_F_POL     2
`define CRS_F_FALL    3
`define CRS_F_UP      4
`define CRS_F_XDIR    5
`define CRS_F_GM      6
`define CRS_F_SSEL    8
`define CRS_F_GSEL    12

// ****************************************
// Pin, trigger and route fields
// ****************************************
`define CRS_F_PIN_HI  16
`define CRS_F_C0PIN   16
`define CRS_F_EXTTB   17
`define CRS_F_AISAMP  0
`define CRS_F_AISTRT  1
`define CRS_F_AICONV  2
`define CRS_F_AOSAMP  3
`define CRS_F_DOSAMP  4
`define CRS_F_DISAMP  5
`define CRS_F_DIVN    8
`define CRS_F_DIVSLOW 12

// ****************************************
// Selector codes
// ****************************************
`define CRS_SRC_ROOT  4'hA
`define CRS_SRC_SLOW  4'hB
`define CRS_SRC_PEER  4'hC
`define CRS_GATE_PEER 4'hA
`define CRS_GM_FREE   2'h0
`define CRS_GM_LEVEL  2'h1
`define CRS_GM_EDGE   2'h2
`define CRS_GM_LATCH  2'h3
`define CRS_TB_OFF    2'h0
`define CRS_TB_CTR0   2'h1
`define CRS_TB_PIN    2'h2
`define CRS_TB_DIV    2'h3

// ****************************************
// Dedicated function pin numbers and reset
// ****************************************
`define CRS_PIN_SRC1  3
`define CRS_PIN_GATE1 4
`define CRS_PIN_SRC0  8
`define CRS_PIN_GATE0 9
`define CRS_RST_WORD  32'h0000_0000

`endif

//--- crs_counter.v
// One general-purpose counter: source edge, gate, direction and output shaping
`timescale 1ns/1ps
`include "crs_consts.vh"

module crs_counter #(
  parameter WIDTH = 24
) (
  input  wire             i_clk_sys,
  input  wire             i_rstn,
  input  wire             i_ce,
  input  wire             i_src,
  input  wire             i_src_fall,
  input  wire             i_gate,
  input  wire [1:0]       i_gate_mode,
  input  wire             i_arm,
  input  wire             i_ext_dir_en,
  input  wire             i_dir_line,
  input  wire             i_dir_up,
  input  wire             i_tog,
  input  wire             i_pol,
  input  wire             i_load,
  input  wire [WIDTH-1:0] i_load_val,
  output reg  [WIDTH-1:0] o_count,
  output reg  [WIDTH-1:0] o_latch,
  output reg              o_tc,
  output reg              o_gate_evt,
  output reg              o_out
);

  reg  src_d_reg;
  reg  gate_d_reg;
  reg  run_reg;
  reg  tstate_reg;
  wire src_edge;
  wire gate_rise;
  wire enable;
  wire up;
  wire wrap;

  assign src_edge  = i_src_fall ? (src_d_reg & ~i_src) : (i_src & ~src_d_reg);
  assign gate_rise = i_gate & ~gate_d_reg;
  assign enable    = (i_gate_mode == `CRS_GM_LEVEL) ? i_gate :
                     (i_gate_mode == `CRS_GM_EDGE) ? run_reg : 1'b1;
  assign up        = i_ext_dir_en ? i_dir_line : i_dir_up;
  assign wrap      = i_arm & enable & src_edge & (up ? (&o_count) : ~(|o_count));

  always @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      src_d_reg  <= 1'b0;
      gate_d_reg <= 1'b0;
      run_reg    <= 1'b0;
      tstate_reg <= 1'b0;
      o_count    <= {WIDTH{1'b0}};
      o_latch    <= {WIDTH{1'b0}};
      o_tc       <= 1'b0;
      o_gate_evt <= 1'b0;
      o_out      <= 1'b0;
    end else if (i_ce) begin
      src_d_reg  <= i_src;
      gate_d_reg <= i_gate;
      o_tc       <= wrap;
      o_gate_evt <= gate_rise & (i_gate_mode != `CRS_GM_FREE);
      if (gate_rise && i_gate_mode == `CRS_GM_EDGE) begin
        run_reg <= ~run_reg;
      end
      if (gate_rise && i_gate_mode == `CRS_GM_LATCH) begin
        o_latch <= o_count;
      end
      if (i_load) begin
        o_count    <= i_load_val;
        tstate_reg <= 1'b0;
      end else if (i_arm && enable && src_edge) begin
        if (wrap) begin
          o_count <= i_load_val;
        end else if (up) begin
          o_count <= o_count + {{(WIDTH-1){1'b0}}, 1'b1};
        end else begin
          o_count <= o_count - {{(WIDTH-1){1'b0}}, 1'b1};
        end
        if (wrap) begin
          tstate_reg <= ~tstate_reg;
        end
      end
      // Toggle or pulse on terminal count, then polarity
      o_out <= i_pol ^ (i_tog ? (tstate_reg ^ wrap) : wrap);
    end
  end

endmodule // crs_counter

//--- crs_ext_model.sv
// Far side: pulse source, pull-ups and direction lines
`timescale 1ns/1ps
module crs_ext_model (
  input  wire       i_clk_sys,
  input  wire       i_run,
  input  wire [3:0] i_sel,
  input  wire [1:0] i_dir,
  input  wire [9:0] i_pin_drv,
  input  wire [9:0] i_pin_oe_n,
  input  wire [6:0] i_trg_drv,
  input  wire [6:0] i_trg_oe_n,
  output wire [9:0] o_pin,
  output wire [7:0] o_trg,
  output wire [1:0] o_dir
);
  reg         lvl = 1'b1;
  reg         ph = 1'b0;
  wire [10:0] hot = 11'h001 << i_sel;
  wire [10:0] ext = ~hot | {11{lvl}};
  // Released lines float high on the pull-ups, except the line picked by i_sel, which carries the pulses
  assign o_pin = ext[9:0] & i_pin_oe_n | i_pin_drv & ~i_pin_oe_n;
  assign o_trg = {ext[10], 7'h7F & i_trg_oe_n | i_trg_drv & ~i_trg_oe_n};
  assign o_dir = i_dir;
  always @(posedge i_clk_sys) begin
    if (i_run) begin
      ph <= ~ph;
      if (ph)
        lvl <= ~lvl;
    end
  end
endmodule // crs_ext_model

//--- crs_top.v
// Counter signal router: two counters, function pins, trigger bus and divider
`timescale 1ns/1ps
`include "crs_consts.vh"

module crs_top #(
  parameter WIDTH      = 24,
  parameter NPIN       = 10,
  parameter NTRIG      = 7,
  parameter HAS_AO_RTE = 1
) (
  input  wire             i_clk_sys,
  input  wire             i_rstn,
  input  wire             i_ce,
  input  wire [7:0]       i_addr,
  input  wire [31:0]      i_wdata,
  input  wire             i_wr,
  input  wire             i_rd,
  output reg  [31:0]      o_rdata,
  input  wire [NPIN-1:0]  i_function_pin,
  output reg  [NPIN-1:0]  o_function_pin,
  output reg  [NPIN-1:0]  o_function_pin_oe_n,
  input  wire [7:0]       i_shared_trigger_bus,
  output reg  [NTRIG-1:0] o_shared_trigger_bus,
  output reg  [NTRIG-1:0] o_shared_trigger_bus_oe_n,
  input  wire             i_counter_zero_pin,
  output reg              o_counter_zero_pin,
  output reg              o_counter_zero_pin_oe_n,
  output reg              o_counter_one_pin,
  input  wire             i_direction_line_zero,
  input  wire             i_direction_line_one,
  input  wire             i_fast_internal_timebase,
  input  wire             i_mid_internal_timebase,
  input  wire             i_slow_internal_timebase,
  output reg              o_ai_sample_clk,
  output reg              o_ai_start_trig,
  output reg              o_ai_convert_clk,
  output reg              o_ao_sample_clk,
  output reg              o_do_sample_clk,
  output reg              o_di_sample_clk,
  output reg              o_divided_clock_out
);

  // ****************************************
  // Registers
  // ****************************************
  reg  [15:0]      ctrl0_reg;
  reg  [15:0]      ctrl1_reg;
  reg  [WIDTH-1:0] load0_reg;
  reg  [WIDTH-1:0] load1_reg;
  reg              ld0_reg;
  reg              ld1_reg;
  reg  [NPIN-1:0]  pin_pol_reg;
  reg  [NPIN-1:0]  pin_edge_reg;
  reg  [NPIN-1:0]  pin_oe_reg;
  reg  [NPIN-1:0]  pin_div_reg;
  reg  [17:0]      trig_reg;
  reg  [12:0]      route_reg;
  reg  [3:0]       status_reg;
  reg  [3:0]       status_next;
  reg  [31:0]      rdata_next;

  wire wr_ctrl0  = i_wr && i_addr == `CRS_A_CTRL0;
  wire wr_ctrl1  = i_wr && i_addr == `CRS_A_CTRL1;
  wire wr_load0  = i_wr && i_addr == `CRS_A_LOAD0;
  wire wr_load1  = i_wr && i_addr == `CRS_A_LOAD1;
  wire wr_pincfg = i_wr && i_addr == `CRS_A_PINCFG;
  wire wr_pinout = i_wr && i_addr == `CRS_A_PINOUT;
  wire wr_trig   = i_wr && i_addr == `CRS_A_TRIG;
  wire wr_route  = i_wr && i_addr == `CRS_A_ROUTE;
  wire wr_status = i_wr && i_addr == `CRS_A_STATUS;

  // ****************************************
  // Function pin input conditioning
  // ****************************************
  wire [NPIN-1:0] pin_lvl;
  wire [NPIN-1:0] pin_sig;
  reg  [NPIN-1:0] pin_d_reg;

  assign pin_lvl = i_function_pin ^ pin_pol_reg;

  genvar g;
  generate
    for (g = 0; g < NPIN; g = g + 1) begin : g_pin_in
      always @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
          pin_d_reg[g] <= 1'b0;
        end else if (i_ce) begin
          pin_d_reg[g] <= pin_lvl[g];
        end
      end
      // Edge mode yields a one-cycle pulse, level mode passes through
      assign pin_sig[g] = pin_edge_reg[g] ? (pin_lvl[g] & ~pin_d_reg[g]) : pin_lvl[g];
    end
  endgenerate

  // ****************************************
  // Timebase and source/gate selection
  // ****************************************
  wire root_timebase;
  wire c0_out;
  wire c1_out;

  assign root_timebase = trig_reg[`CRS_F_EXTTB] ? i_shared_trigger_bus[7]
                                                : i_fast_internal_timebase;

  function sel_src;
    input [3:0]      s;
    input [NPIN-1:0] p;
    input            root;
    input            slow;
    input            peer;
    begin
      if (s < NPIN) begin
        sel_src = p[s];
      end else if (s == `CRS_SRC_ROOT) begin
        sel_src = root;
      end else if (s == `CRS_SRC_SLOW) begin
        sel_src = slow;
      end else if (s == `CRS_SRC_PEER) begin
        sel_src = peer;
      end else begin
        sel_src = 1'b0;
      end
    end
  endfunction

  function sel_gate;
    input [3:0]      s;
    input [NPIN-1:0] p;
    input            peer;
    begin
      if (s < NPIN) begin
        sel_gate = p[s];
      end else if (s == `CRS_GATE_PEER) begin
        sel_gate = peer;
      end else begin
        sel_gate = 1'b0;
      end
    end
  endfunction

  wire src0 = sel_src(ctrl0_reg[`CRS_F_SSEL+3:`CRS_F_SSEL], pin_sig, root_timebase,
                      i_slow_internal_timebase, c1_out);
  wire src1 = sel_src(ctrl1_reg[`CRS_F_SSEL+3:`CRS_F_SSEL], pin_sig, root_timebase,
                      i_slow_internal_timebase, c0_out);
  wire gate0 = sel_gate(ctrl0_reg[`CRS_F_GSEL+3:`CRS_F_GSEL], pin_sig, c1_out);
  wire gate1 = sel_gate(ctrl1_reg[`CRS_F_GSEL+3:`CRS_F_GSEL], pin_sig, c0_out);

  // ****************************************
  // Counters
  // ****************************************
  wire [WIDTH-1:0] count0;
  wire [WIDTH-1:0] count1;
  wire [WIDTH-1:0] latch0;
  wire [WIDTH-1:0] latch1;
  wire             tc0;
  wire             tc1;
  wire             gev0;
  wire             gev1;

  crs_counter #(.WIDTH(WIDTH)) u_ctr0 (
    .i_clk_sys    (i_clk_sys),
    .i_rstn       (i_rstn),
    .i_ce         (i_ce),
    .i_src        (src0),
    .i_src_fall   (ctrl0_reg[`CRS_F_FALL]),
    .i_gate       (gate0),
    .i_gate_mode  (ctrl0_reg[`CRS_F_GM+1:`CRS_F_GM]),
    .i_arm        (ctrl0_reg[`CRS_F_ARM]),
    .i_ext_dir_en (ctrl0_reg[`CRS_F_XDIR]),
    .i_dir_line   (i_direction_line_zero),
    .i_dir_up     (ctrl0_reg[`CRS_F_UP]),
    .i_tog        (ctrl0_reg[`CRS_F_TOG]),
    .i_pol        (ctrl0_reg[`CRS_F_POL]),
    .i_load       (ld0_reg),
    .i_load_val   (load0_reg),
    .o_count      (count0),
    .o_latch      (latch0),
    .o_tc         (tc0),
    .o_gate_evt   (gev0),
    .o_out        (c0_out)
  );

  crs_counter #(.WIDTH(WIDTH)) u_ctr1 (
    .i_clk_sys    (i_clk_sys),
    .i_rstn       (i_rstn),
    .i_ce         (i_ce),
    .i_src        (src1),
    .i_src_fall   (ctrl1_reg[`CRS_F_FALL]),
    .i_gate       (gate1),
    .i_gate_mode  (ctrl1_reg[`CRS_F_GM+1:`CRS_F_GM]),
    .i_arm        (ctrl1_reg[`CRS_F_ARM]),
    .i_ext_dir_en (ctrl1_reg[`CRS_F_XDIR]),
    .i_dir_line   (i_direction_line_one),
    .i_dir_up     (ctrl1_reg[`CRS_F_UP]),
    .i_tog        (ctrl1_reg[`CRS_F_TOG]),
    .i_pol        (ctrl1_reg[`CRS_F_POL]),
    .i_load       (ld1_reg),
    .i_load_val   (load1_reg),
    .o_count      (count1),
    .o_latch      (latch1),
    .o_tc         (tc1),
    .o_gate_evt   (gev1),
    .o_out        (c1_out)
  );

  // ****************************************
  // Frequency divider
  // ****************************************
  reg  [3:0] div_cnt_reg;
  reg        div_tb_d_reg;
  wire [3:0] div_n   = route_reg[`CRS_F_DIVN+3:`CRS_F_DIVN];
  wire       div_tb  = route_reg[`CRS_F_DIVSLOW] ? i_slow_internal_timebase
                                                : i_mid_internal_timebase;
  wire       div_rise = div_tb & ~div_tb_d_reg;
  wire [4:0] div_half = ({1'b0, div_n} + 5'h02) >> 1;
  wire       div_clk  = (div_n == 4'h0) ? div_tb
                                        : ({1'b0, div_cnt_reg} < div_half);

  always @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      div_cnt_reg  <= 4'h0;
      div_tb_d_reg <= 1'b0;
    end else if (i_ce) begin
      div_tb_d_reg <= div_tb;
      if (div_rise) begin
        if (div_cnt_reg >= div_n) begin
          div_cnt_reg <= 4'h0;
        end else begin
          div_cnt_reg <= div_cnt_reg + 4'h1;
        end
      end
    end
  end

  // ****************************************
  // Pin and trigger bus outputs
  // ****************************************
  reg [NPIN-1:0] pin_asg;

  always @* begin
    pin_asg                 = {NPIN{1'b0}};
    pin_asg[`CRS_PIN_SRC1]  = src1;
    pin_asg[`CRS_PIN_GATE1] = gate1;
    pin_asg[`CRS_PIN_SRC0]  = src0;
    pin_asg[`CRS_PIN_GATE0] = gate0;
  end

  generate
    for (g = 0; g < NPIN; g = g + 1) begin : g_pin_out
      always @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
          o_function_pin[g]      <= 1'b0;
          o_function_pin_oe_n[g] <= 1'b1;
        end else if (i_ce) begin
          // Only the pin's own signal or the divided clock, which is the raw timebase when div_n is 0
          o_function_pin[g]      <= pin_div_reg[g] ? div_clk : pin_asg[g];
          o_function_pin_oe_n[g] <= ~pin_oe_reg[g];
        end
      end
    end
    for (g = 0; g < NTRIG; g = g + 1) begin : g_trig_out
      wire [1:0] code = trig_reg[2*g+1:2*g];
      always @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
          o_shared_trigger_bus[g]      <= 1'b0;
          o_shared_trigger_bus_oe_n[g] <= 1'b1;
        end else if (i_ce) begin
          case (code)
            `CRS_TB_CTR0: o_shared_trigger_bus[g] <= c0_out;
            `CRS_TB_PIN:  o_shared_trigger_bus[g] <= i_counter_zero_pin;
            `CRS_TB_DIV:  o_shared_trigger_bus[g] <= div_clk;
            default:      o_shared_trigger_bus[g] <= 1'b0;
          endcase
          o_shared_trigger_bus_oe_n[g] <= (code == `CRS_TB_OFF);
        end
      end
    end
  endgenerate

  // ****************************************
  // Dedicated outputs and internal routes
  // ****************************************
  always @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      o_counter_zero_pin      <= 1'b0;
      o_counter_zero_pin_oe_n <= 1'b1;
      o_counter_one_pin       <= 1'b0;
      o_ai_sample_clk         <= 1'b0;
      o_ai_start_trig         <= 1'b0;
      o_ai_convert_clk        <= 1'b0;
      o_ao_sample_clk         <= 1'b0;
      o_do_sample_clk         <= 1'b0;
      o_di_sample_clk         <= 1'b0;
      o_divided_clock_out     <= 1'b0;
    end else if (i_ce) begin
      o_counter_zero_pin      <= c0_out;
      o_counter_zero_pin_oe_n <= ~trig_reg[`CRS_F_C0PIN];
      o_counter_one_pin       <= c1_out;
      o_ai_sample_clk         <= route_reg[`CRS_F_AISAMP] & c0_out;
      o_ai_start_trig         <= route_reg[`CRS_F_AISTRT] & c0_out;
      o_ai_convert_clk        <= route_reg[`CRS_F_AICONV] & c0_out;
      o_ao_sample_clk         <= (HAS_AO_RTE != 0) & route_reg[`CRS_F_AOSAMP] & c1_out;
      o_do_sample_clk         <= route_reg[`CRS_F_DOSAMP] & div_clk;
      o_di_sample_clk         <= route_reg[`CRS_F_DISAMP] & div_clk;
      o_divided_clock_out     <= div_clk;
    end
  end

  // ****************************************
  // Register bus
  // ****************************************
  always @* begin
    // Hardware set wins over a write-one clear in the same cycle
    status_next = wr_status ? (status_reg & ~i_wdata[3:0]) : status_reg;
    status_next = status_next | {gev1, gev0, tc1, tc0};
    rdata_next  = `CRS_RST_WORD;
    case (i_addr)
      `CRS_A_CTRL0:  rdata_next[15:0] = ctrl0_reg;
      `CRS_A_CTRL1:  rdata_next[15:0] = ctrl1_reg;
      `CRS_A_LOAD0:  rdata_next[WIDTH-1:0] = load0_reg;
      `CRS_A_LOAD1:  rdata_next[WIDTH-1:0] = load1_reg;
      `CRS_A_COUNT0: rdata_next[WIDTH-1:0] = count0;
      `CRS_A_COUNT1: rdata_next[WIDTH-1:0] = count1;
      `CRS_A_LATCH0: rdata_next[WIDTH-1:0] = latch0;
      `CRS_A_LATCH1: rdata_next[WIDTH-1:0] = latch1;
      `CRS_A_PINCFG: rdata_next = {6'h00, pin_edge_reg, 6'h00, pin_pol_reg};
      `CRS_A_PINOUT: rdata_next = {6'h00, pin_div_reg, 6'h00, pin_oe_reg};
      `CRS_A_TRIG:   rdata_next[17:0] = trig_reg;
      `CRS_A_ROUTE:  rdata_next[12:0] = route_reg;
      `CRS_A_STATUS: rdata_next[9:0] = {c1_out, c0_out, 4'h0, status_reg};
      default:       rdata_next = `CRS_RST_WORD;
    endcase
  end

  always @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      ctrl0_reg    <= 16'h0000;
      ctrl1_reg    <= 16'h0000;
      load0_reg    <= {WIDTH{1'b0}};
      load1_reg    <= {WIDTH{1'b0}};
      ld0_reg      <= 1'b0;
      ld1_reg      <= 1'b0;
      pin_pol_reg  <= {NPIN{1'b0}};
      pin_edge_reg <= {NPIN{1'b0}};
      pin_oe_reg   <= {NPIN{1'b0}};
      pin_div_reg  <= {NPIN{1'b0}};
      trig_reg     <= 18'h00000;
      route_reg    <= 13'h0000;
      status_reg   <= 4'h0;
      o_rdata      <= `CRS_RST_WORD;
    end else if (i_ce) begin
      ld0_reg    <= wr_load0;
      ld1_reg    <= wr_load1;
      status_reg <= status_next;
      o_rdata    <= i_rd ? rdata_next : `CRS_RST_WORD;
      if (wr_ctrl0) begin
        ctrl0_reg <= i_wdata[15:0];
      end
      if (wr_ctrl1) begin
        ctrl1_reg <= i_wdata[15:0];
      end
      if (wr_load0) begin
        load0_reg <= i_wdata[WIDTH-1:0];
      end
      if (wr_load1) begin
        load1_reg <= i_wdata[WIDTH-1:0];
      end
      if (wr_pincfg) begin
        pin_pol_reg  <= i_wdata[NPIN-1:0];
        pin_edge_reg <= i_wdata[`CRS_F_PIN_HI+NPIN-1:`CRS_F_PIN_HI];
      end
      if (wr_pinout) begin
        pin_oe_reg  <= i_wdata[NPIN-1:0];
        pin_div_reg <= i_wdata[`CRS_F_PIN_HI+NPIN-1:`CRS_F_PIN_HI];
      end
      if (wr_trig) begin
        trig_reg <= i_wdata[17:0];
      end
      if (wr_route) begin
        route_reg <= i_wdata[12:0];
      end
    end
  end

endmodule // crs_top

//--- crs_top_assertions.sv
// Port checker of the counter signal router
`timescale 1ns/1ps
`include "crs_consts.vh"
module crs_chk #(
  parameter NPIN  = 10,
  parameter NTRIG = 7
) (
  input wire             i_clk_sys,
  input wire             i_rstn,
  input wire [7:0]       i_addr,
  input wire [31:0]      i_wdata,
  input wire             i_wr,
  input wire             i_rd,
  input wire [31:0]      o_rdata,
  input wire [NPIN-1:0]  o_function_pin_oe_n,
  input wire [NTRIG-1:0] o_shared_trigger_bus_oe_n,
  input wire             o_counter_zero_pin,
  input wire             o_counter_zero_pin_oe_n,
  input wire             o_counter_one_pin,
  input wire             o_ai_sample_clk,
  input wire             o_ai_start_trig,
  input wire             o_ai_convert_clk,
  input wire             o_ao_sample_clk,
  input wire             o_do_sample_clk,
  input wire             o_di_sample_clk
);
  reg [9:0]  pout;
  reg [16:0] trg;
  reg [5:0]  rte;
  reg [2:0]  age;
  reg [6:0]  ton;
  wire       st = age == 3'h7;
  integer    k;
  // Trigger line enabled when its selector is not off
  always @* begin
    for (k = 0; k < 7; k = k + 1)
      ton[k] = |trg[2*k+:2];
  end
  // Shadow of routing registers, settle age after any write
  always @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      pout <= 10'h000;
      trg  <= 17'h00000;
      rte  <= 6'h00;
      age  <= 3'h0;
    end else if (i_wr) begin
      age <= 3'h0;
      if (i_addr == `CRS_A_PINOUT)
        pout <= i_wdata[9:0];
      if (i_addr == `CRS_A_TRIG)
        trg <= i_wdata[16:0];
      if (i_addr == `CRS_A_ROUTE)
        rte <= i_wdata[5:0];
    end else if (!st) begin
      age <= age + 3'h1;
    end
  end
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rstn);
  property p_rd_idle; !i_rd |=> o_rdata == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data out of slot");
  property p_hiz;
    !$past(i_rstn) |-> &o_function_pin_oe_n && &o_shared_trigger_bus_oe_n
                       && o_counter_zero_pin_oe_n;
  endproperty
  a_hiz: assert property (p_hiz) else $error("driver on after reset");
  property p_pin_oe; st |-> o_function_pin_oe_n == ~pout; endproperty
  a_pin_oe: assert property (p_pin_oe) else $error("pin enable wrong");
  property p_trg_oe; st |-> o_shared_trigger_bus_oe_n == ~ton; endproperty
  a_trg_oe: assert property (p_trg_oe) else $error("bus enable wrong");
  property p_c0_oe; st |-> o_counter_zero_pin_oe_n == !trg[16]; endproperty
  a_c0_oe: assert property (p_c0_oe) else $error("out pin enable wrong");
  property p_c0_val;
    st && trg[16] && rte[2] |-> o_counter_zero_pin == o_ai_convert_clk;
  endproperty
  a_c0_val: assert property (p_c0_val) else $error("out pin value wrong");
  property p_ai_pair;
    st && rte[0] && rte[1] |-> o_ai_sample_clk == o_ai_start_trig;
  endproperty
  a_ai_pair: assert property (p_ai_pair) else $error("ai clocks differ");
  property p_ai_off; st && !rte[0] |-> !o_ai_sample_clk; endproperty
  a_ai_off: assert property (p_ai_off) else $error("ai clock unrouted");
  property p_ao; st && rte[3] |-> o_ao_sample_clk == o_counter_one_pin; endproperty
  a_ao: assert property (p_ao) else $error("ao clock wrong");
  property p_dig; st && rte[4] && rte[5] |-> o_do_sample_clk == o_di_sample_clk; endproperty
  a_dig: assert property (p_dig) else $error("digital clocks differ");
endmodule // crs_chk

bind crs_top crs_chk #(.NPIN(NPIN), .NTRIG(NTRIG)) u_chk (.*);
